// ---- hdl/dpc_pkg.sv ----
// Package with constants and types for the digital pattern compare alarm
package dpc_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int unsigned NUM_CH     = 4;
  localparam int unsigned CH_IDX_W   = 2;
  localparam int unsigned DATA_W     = 32;

  // ----------------------------------------
  // Width codes
  // ----------------------------------------
  localparam logic [1:0] WIDTH_8     = 2'h0;
  localparam logic [1:0] WIDTH_16    = 2'h1;
  localparam logic [1:0] WIDTH_32    = 2'h2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] MASK_RST   = 32'h0000_0000;
  localparam logic [31:0] ALARM_RST  = 32'h0000_0000;
  localparam logic        ENABLE_RST = 1'h0;
  localparam logic        KIND_RST   = 1'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic
  {
    DPC_KIND_EQUAL,
    DPC_KIND_MISMATCH
  } dpc_kind_e;

  typedef enum logic [2:0]
  {
    DPC_CMD_NONE,
    DPC_CMD_MASK,
    DPC_CMD_ENABLE,
    DPC_CMD_KIND,
    DPC_CMD_ALARM
  } dpc_cmd_e;

  typedef struct packed
  {
    logic                valid;
    dpc_cmd_e            cmd;
    logic                use_list;
    logic [NUM_CH-1:0]   ch_list;
    logic [DATA_W-1:0]   value;
  } dpc_cmd_s;

  typedef struct packed
  {
    logic [DATA_W-1:0]   mask;
    logic [DATA_W-1:0]   alarm_value;
    logic                enable;
    dpc_kind_e           kind;
  } dpc_cfg_s;

endpackage

// ---- hdl/dpc_cfg_store.sv ----
// Per-channel settings store with registered readback
`timescale 1ns/1ps

module dpc_cfg_store
  import dpc_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   factory_reset_i,
  // Write side
  input  wire logic [dpc_pkg::NUM_CH-1:0] wr_en_i,
  input  wire dpc_pkg::dpc_cmd_e      wr_cmd_i,
  input  wire logic [31:0]            wr_value_i [dpc_pkg::NUM_CH],
  // Read side
  input  wire logic [dpc_pkg::CH_IDX_W-1:0] rd_ch_i,
  output dpc_pkg::dpc_cfg_s           rd_cfg_o,
  output dpc_pkg::dpc_cfg_s           cfg_o [dpc_pkg::NUM_CH]
);

  dpc_cfg_s cfg_r [NUM_CH];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Only reset_n_i and factory reset clear; preset and card reset never reach this block
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        cfg_r[i].mask        <= MASK_RST;
        cfg_r[i].alarm_value <= ALARM_RST;
        cfg_r[i].enable      <= ENABLE_RST;
        cfg_r[i].kind        <= dpc_kind_e'(KIND_RST);
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (factory_reset_i)
        begin
          cfg_r[i].mask        <= MASK_RST;
          cfg_r[i].alarm_value <= ALARM_RST;
          cfg_r[i].enable      <= ENABLE_RST;
          cfg_r[i].kind        <= dpc_kind_e'(KIND_RST);
        end
        else if (wr_en_i[i])
        begin
          unique case (wr_cmd_i)
            DPC_CMD_MASK:   cfg_r[i].mask        <= wr_value_i[i];
            DPC_CMD_ALARM:  cfg_r[i].alarm_value <= wr_value_i[i];
            DPC_CMD_ENABLE: cfg_r[i].enable      <= wr_value_i[i][0];
            DPC_CMD_KIND:   cfg_r[i].kind        <= dpc_kind_e'(wr_value_i[i][0]);
            default:        ;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Readback
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rd_cfg_o <= '0;
    else
      rd_cfg_o <= cfg_r[rd_ch_i];
  end

  assign cfg_o = cfg_r;

endmodule

// ---- hdl/dpc_compare_alarm.sv ----
// Digital pattern compare alarm for the digital io channels
`timescale 1ns/1ps

module dpc_compare_alarm
  import dpc_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_n_i,
  // Reset commands
  input  wire logic                    factory_reset_i,
  input  wire logic                    preset_i,
  input  wire logic                    card_reset_command_i,
  // Configuration
  input  wire logic [1:0]              ch_width_i [dpc_pkg::NUM_CH],
  input  wire logic [dpc_pkg::NUM_CH-1:0] is_digital_io_channel_i,
  input  wire logic [dpc_pkg::NUM_CH-1:0] scan_list_i,
  // Command port
  input  wire dpc_pkg::dpc_cmd_s       cmd_i,
  input  wire logic [dpc_pkg::CH_IDX_W-1:0] query_ch_i,
  // Channel inputs from pins
  input  wire logic [31:0]             digital_in_i [dpc_pkg::NUM_CH],
  // Status
  output logic [31:0]                  query_mask_o,
  output logic [31:0]                  query_alarm_value_o,
  output logic                         query_enable_o,
  output logic                         query_mismatch_kind_o,
  output logic [dpc_pkg::NUM_CH-1:0]   alarm_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] width_mask(input logic [1:0] w);
    unique case (w)
      WIDTH_8:  width_mask = 32'h0000_00ff;
      WIDTH_16: width_mask = 32'h0000_ffff;
      default:  width_mask = 32'hffff_ffff;
    endcase
  endfunction

  // A command reaches its own list, else the scan list, and never a non-io channel
  function automatic logic [NUM_CH-1:0] target_set(input dpc_cmd_s          c,
                                                   input logic [NUM_CH-1:0] scan,
                                                   input logic [NUM_CH-1:0] digital_io_channel);
    target_set = '0;
    if (c.valid && (c.cmd != DPC_CMD_NONE))
    begin
      target_set = c.use_list ? c.ch_list : scan;
      target_set = target_set & digital_io_channel;
    end
  endfunction

  // ----------------------------------------
  // Write helpers
  // ----------------------------------------
  // Each target trims to its own width, so one command may reach mixed widths
  function automatic logic [31:0] trim_value(input dpc_cmd_e    c,
                                             input logic [31:0] v,
                                             input logic [1:0]  w);
    if (c == DPC_CMD_ENABLE || c == DPC_CMD_KIND)
      trim_value = {31'h0000_0000, v[0]};
    else
      trim_value = v & width_mask(w);
  endfunction

  // ----------------------------------------
  // Compare helpers
  // ----------------------------------------
  // Only active mask bits inside the current width take part
  function automatic logic [31:0] masked_diff(input logic [31:0] din,
                                              input logic [31:0] alarm_value,
                                              input logic [31:0] mask,
                                              input logic [1:0]  w);
    masked_diff = (din ^ alarm_value) & mask & width_mask(w);
  endfunction

  function automatic logic pattern_alarm(input dpc_kind_e   kind,
                                         input logic [31:0] diff);
    if (kind == DPC_KIND_EQUAL)
      pattern_alarm = (diff == 32'h0000_0000);
    else
      pattern_alarm = (diff != 32'h0000_0000);
  endfunction

  logic [31:0]          din_meta_r [NUM_CH];
  logic [31:0]          din_sync_r [NUM_CH];
  logic [NUM_CH-1:0]    wr_en;
  logic [31:0]          wr_value [NUM_CH];
  dpc_cfg_s             rd_cfg;
  dpc_cfg_s             cfg [NUM_CH];
  logic [NUM_CH-1:0]    alarm_nxt;
  logic [NUM_CH-1:0]    alarm_r;

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  // First stage may go metastable; nothing but the second stage reads it
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        din_meta_r[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        din_meta_r[i] <= digital_in_i[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        din_sync_r[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        din_sync_r[i] <= din_meta_r[i];
      end
    end
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // Preset and card reset are deliberately not wired into the store
  assign wr_en = target_set(cmd_i, scan_list_i, is_digital_io_channel_i);

  // ----------------------------------------
  // Write trim
  // ----------------------------------------
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      wr_value[i] = trim_value(cmd_i.cmd, cmd_i.value, ch_width_i[i]);
    end
  end

  // ----------------------------------------
  // Settings store
  // ----------------------------------------
  dpc_cfg_store u_store
  (
    .ref_clk_i       (ref_clk_i),
    .reset_n_i       (reset_n_i),
    .factory_reset_i (factory_reset_i),
    .wr_en_i         (wr_en),
    .wr_cmd_i        (cmd_i.cmd),
    .wr_value_i      (wr_value),
    .rd_ch_i         (query_ch_i),
    .rd_cfg_o        (rd_cfg),
    .cfg_o           (cfg)
  );

  // ----------------------------------------
  // Query outputs
  // ----------------------------------------
  assign query_mask_o          = rd_cfg.mask;
  assign query_alarm_value_o   = rd_cfg.alarm_value;
  assign query_enable_o        = rd_cfg.enable;
  assign query_mismatch_kind_o = (rd_cfg.kind == DPC_KIND_MISMATCH);

  // ----------------------------------------
  // Comparison
  // ----------------------------------------
  // Width change applies at once to the compare, so stale high bits never alarm
  always_comb
  begin
    alarm_nxt = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (cfg[i].enable && is_digital_io_channel_i[i])
        alarm_nxt[i] = pattern_alarm(cfg[i].kind,
                                     masked_diff(din_sync_r[i],
                                                 cfg[i].alarm_value,
                                                 cfg[i].mask,
                                                 ch_width_i[i]));
    end
  end

  // ----------------------------------------
  // Alarm register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      alarm_r <= '0;
    else
      alarm_r <= alarm_nxt;
  end

  // Preset inputs exist only so the system sees they change nothing
  assign alarm_o = alarm_r;

endmodule

// ---- tb/dpc_checker.sv ----
// Checker of the pattern compare alarm ports
`timescale 1ns/1ps
module dpc_checker
  import dpc_pkg::*;
(
  // Watched ports
  input wire logic              ref_clk_i,
  input wire logic              reset_n_i,
  input wire logic              factory_reset_i,
  input wire logic              preset_i,
  input wire logic              card_reset_command_i,
  input wire logic [1:0]        ch_width_i [4],
  input wire logic [3:0]        is_digital_io_channel_i,
  input wire logic [3:0]        scan_list_i,
  input wire dpc_pkg::dpc_cmd_s cmd_i,
  input wire logic [1:0]        query_ch_i,
  input wire logic [31:0]       query_mask_o,
  input wire logic [31:0]       query_alarm_value_o,
  input wire logic              query_enable_o,
  input wire logic              query_mismatch_kind_o,
  input wire logic [3:0]        alarm_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  logic [3:0]  tg;
  logic [31:0] tv;
  logic        q;
  logic        hit;
  // Writes are judged only with the queried channel as lone target
  assign tg  = (cmd_i.use_list ? cmd_i.ch_list : scan_list_i) & is_digital_io_channel_i;
  assign q   = !cmd_i.valid && !factory_reset_i;
  assign hit = cmd_i.valid && !factory_reset_i && tg == 4'h1 << query_ch_i;
  assign tv  = cmd_i.value & (ch_width_i[query_ch_i] == WIDTH_8 ? 32'hff :
    ch_width_i[query_ch_i] == WIDTH_16 ? 32'hffff : 32'hffff_ffff);
  sequence s_hold;
    q && $stable(query_ch_i) ##1 $stable(query_ch_i);
  endsequence
  a_mask_trim:
    assert property (hit && cmd_i.cmd == DPC_CMD_MASK ##1 s_hold
      |-> query_mask_o == $past(tv, 2)) else $error("mask readback wrong");
  a_alarm_trim:
    assert property (hit && cmd_i.cmd == DPC_CMD_ALARM ##1 s_hold
      |-> query_alarm_value_o == $past(tv, 2)) else $error("alarm value wrong");
  a_enable_read:
    assert property (hit && cmd_i.cmd == DPC_CMD_ENABLE ##1 s_hold
      |-> query_enable_o == $past(cmd_i.value[0], 2)) else $error("enable wrong");
  a_kind_read:
    assert property (hit && cmd_i.cmd == DPC_CMD_KIND ##1 s_hold
      |-> query_mismatch_kind_o == $past(cmd_i.value[0], 2)) else $error("kind wrong");
  a_factory_clear:
    assert property (factory_reset_i ##1 q |=> query_mask_o == 32'h0 && alarm_o == 4'h0
      && query_alarm_value_o == 32'h0 && !query_enable_o && !query_mismatch_kind_o)
    else $error("factory reset left settings");
  a_preset_keep:
    assert property ((preset_i || card_reset_command_i) && q && $past(q) && $stable(query_ch_i)
      ##1 s_hold
      |-> query_mask_o == $past(query_mask_o, 2) && query_enable_o == $past(query_enable_o, 2)
      && query_mismatch_kind_o == $past(query_mismatch_kind_o, 2)) else $error("preset lost");
  a_idle_silent:
    assert property ((!query_enable_o && q && $stable(query_ch_i)) [*3]
      |-> !alarm_o[query_ch_i]) else $error("alarm while disabled");
  a_nondig_quiet:
    assert property ((alarm_o & ~is_digital_io_channel_i) == 4'h0) else $error("alarm off io");
endmodule

bind dpc_compare_alarm dpc_checker i_chk (
  .ref_clk_i, .reset_n_i, .factory_reset_i, .preset_i, .card_reset_command_i, .ch_width_i,
  .is_digital_io_channel_i, .scan_list_i, .cmd_i, .query_ch_i, .query_mask_o,
  .query_alarm_value_o, .query_enable_o, .query_mismatch_kind_o, .alarm_o);

// ---- tb/dpc_pins_model.sv ----
// Model of the pins that feed the digital io channels
`timescale 1ns/1ps
module dpc_pins_model
  import dpc_pkg::*;
(
  // Clock and requested patterns
  input  wire logic        ref_clk_i,
  input  wire logic [31:0] pat_i [4],
  // Pin levels
  output logic      [31:0] pin_o [4]
);
  // Pins change on each rising edge of ref_clk_i, the same edge that samples them
  always_ff @(posedge ref_clk_i)
  begin
    pin_o <= pat_i;
  end
endmodule

// ---- tb/dpc_compare_alarm_tb_top.sv ----
// Self-checking testbench for the pattern compare alarm
`timescale 1ns/1ps
module dpc_compare_alarm_tb_top;
  import dpc_pkg::*;
  logic        ref_clk_i;
  logic        reset_n_i;
  logic [2:0]  rst_cmd;
  logic [1:0]  cw [4];
  logic [31:0] pat [4];
  logic [31:0] din [4];
  logic [31:0] qm;
  logic [31:0] qa;
  logic        qe;
  logic        qk;
  logic [3:0]  al;
  logic [1:0]  qch;
  dpc_cmd_s    cmd;
  int          errors;
  int          n_checks;

  dpc_pins_model i_pins (.ref_clk_i, .pat_i(pat), .pin_o(din));
  dpc_compare_alarm i_dut (.ref_clk_i, .reset_n_i, .factory_reset_i(rst_cmd[2]),
    .preset_i(rst_cmd[1]), .card_reset_command_i(rst_cmd[0]), .ch_width_i(cw),
    .is_digital_io_channel_i(4'h7), .scan_list_i(4'ha), .cmd_i(cmd), .query_ch_i(qch),
    .digital_in_i(din), .query_mask_o(qm), .query_alarm_value_o(qa), .query_enable_o(qe),
    .query_mismatch_kind_o(qk), .alarm_o(al));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // ----
  // Helpers
  // ----
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task send(input dpc_cmd_e c, input logic [3:0] l, input logic [31:0] v);
    @(posedge ref_clk_i);
    cmd <= {1'b1, c, l != 4'h0, l, v};
    @(posedge ref_clk_i);
    cmd.valid <= 1'b0;
  endtask
  task query(input logic [1:0] ch);
    @(posedge ref_clk_i);
    qch <= ch;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask
  task pulse(input logic [2:0] r);
    @(posedge ref_clk_i);
    rst_cmd <= r;
    @(posedge ref_clk_i);
    rst_cmd <= 3'h0;
  endtask
  // Widths follow cw: 8, 16, 32 bit
  function automatic logic [31:0] wm(input int i);
    return i == 0 ? 32'hff : i == 1 ? 32'hffff : 32'hffff_ffff;
  endfunction

  // ----
  // Scenarios
  // ----
  task t_trim;
    // Mixed widths in one write: each target keeps its own low bits
    send(DPC_CMD_MASK, 4'h6, 32'hdead_be81);
    for (int i = 0; i < 3; i++)
    begin
      if (i == 0)
        send(DPC_CMD_MASK, 4'h1, 32'hdead_be81);
      send(DPC_CMD_ALARM, 4'h1 << i, 32'hcafe_009a);
      query(i[1:0]);
      chk(qm, 32'hdead_be81 & wm(i));
      chk(qa, 32'hcafe_009a & wm(i));
    end
    $display("t_trim done");
  endtask
  task t_match;
    logic [31:0] p [3];
    logic        m [3];
    // Upper bits lie outside the 8 bit width and must be ignored
    p = '{32'hffff_ff80, 32'h0000_0081, 32'h0000_007e};
    m = '{1'b1, 1'b0, 1'b0};
    send(DPC_CMD_ENABLE, 4'h1, 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      send(DPC_CMD_KIND, 4'h1, k);
      query(2'h0);
      chk(qk, k);
      chk(qe, 32'h1);
      for (int j = 0; j < 3; j++)
      begin
        @(posedge ref_clk_i);
        pat[0] <= p[j];
        repeat (6) @(posedge ref_clk_i);
        #1;
        chk(al[0], m[j] ^ k[0]);
      end
    end
    $display("t_match done");
  endtask
  task t_scan;
    send(DPC_CMD_ENABLE, 4'h8, 32'h1);
    send(DPC_CMD_ENABLE, 4'h0, 32'h1);
    for (int i = 1; i < 4; i++)
    begin
      query(i[1:0]);
      chk(qe, i == 1);
    end
    $display("t_scan done");
  endtask
  task t_reset;
    pulse(3'h2);
    pulse(3'h1);
    query(2'h0);
    chk(qm, 32'h81);
    chk(qa, 32'h9a);
    chk({qe, qk}, 32'h3);
    pulse(3'h4);
    query(2'h0);
    chk(qm, 32'h0);
    chk(qa, 32'h0);
    chk({qe, qk, al}, 32'h0);
    $display("t_reset done");
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    errors++;
    conclude;
  end

  initial
  begin
    {reset_n_i, rst_cmd, qch, cmd} = '0;
    cw = '{WIDTH_8, WIDTH_16, WIDTH_32, WIDTH_32};
    pat = '{default: 32'h0};
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    t_trim;
    t_match;
    t_scan;
    t_reset;
    conclude;
  end
endmodule
